// ==== src/fcd_pkg.sv ====
// Constants, command bytes and state codes of the flash command decoder.
// Assumes a single 200 MHz clock shared by every module of the block.
package fcd_pkg;
  localparam int          AW            = 16;
  localparam int          DW            = 16;
  localparam int          NMAIN         = 8;
  localparam int          NSEC          = 4;
  localparam int          NSECT         = NMAIN + NSEC;
  localparam int          TW            = 16;
  localparam logic [1:0]  STROBE_IDLE   = 2'h3;
  localparam logic [11:0] ADDR_UNLK1    = 12'hAAA;
  localparam logic [11:0] ADDR_UNLK2    = 12'h554;
  localparam logic [7:0]  INFO_ID_OFS   = 8'h02;
  localparam logic [7:0]  INFO_PROT_OFS = 8'h04;
  localparam logic [7:0]  CMD_UNLK1     = 8'hAA;
  localparam logic [7:0]  CMD_UNLK2     = 8'h55;
  localparam logic [7:0]  CMD_INFO      = 8'h90;
  localparam logic [7:0]  CMD_PROG      = 8'hA0;
  localparam logic [7:0]  CMD_ERASE     = 8'h80;
  localparam logic [7:0]  CMD_SECT      = 8'h30;
  localparam logic [7:0]  CMD_RESUME    = CMD_SECT;
  localparam logic [7:0]  CMD_BULK      = 8'h10;
  localparam logic [7:0]  CMD_SUSP      = 8'hB0;
  localparam logic [7:0]  CMD_RESET     = 8'hF0;
  localparam logic [7:0]  CMD_BYPASS    = 8'h20;
  localparam logic [7:0]  CMD_BYP_EXIT  = 8'h00;
  localparam logic [7:0]  PROT_NO       = 8'h00;
  localparam logic [7:0]  PROT_YES      = 8'h01;
  localparam int          CLK_MHZ       = 200;
  localparam int          ERASE_WIN_US  = 80;
  localparam int          PROT_REV_US   = 100;
  localparam int          ERASE_WIN_CYC = ERASE_WIN_US * CLK_MHZ;
  localparam int          PROT_REV_CYC  = PROT_REV_US * CLK_MHZ;
  localparam int          IBT_CYC       = 2048;

  typedef enum logic [11:0] {
    ST_READ  = 12'h001,
    ST_C1    = 12'h002,
    ST_C2    = 12'h004,
    ST_PROG  = 12'h008,
    ST_E1    = 12'h010,
    ST_E2    = 12'h020,
    ST_E3    = 12'h040,
    ST_EQ    = 12'h080,
    ST_INFO  = 12'h100,
    ST_BYP   = 12'h200,
    ST_BPROG = 12'h400,
    ST_BRST  = 12'h800
  } fcd_state_t;
endpackage : fcd_pkg

// ==== src/fcd_bus_if.sv ====
// Synchronised microcontroller bus cycle as seen by the decoder.
// Driven only by the pin synchroniser, read only by the decoder.
`timescale 1ns/1ps
`default_nettype none
interface fcd_bus_if;
  import fcd_pkg::*;
  logic             wr_n;
  logic             rd_n;
  logic             byte_wr;
  logic [AW-1:0]    addr;
  logic [DW-1:0]    data;
  logic [NSECT-1:0] sel;
  modport src (output wr_n, rd_n, byte_wr, addr, data, sel);
  modport dst (input wr_n, rd_n, byte_wr, addr, data, sel);
endinterface : fcd_bus_if
`default_nettype wire

// ==== src/fcd_pin_sync.sv ====
// Two-stage synchroniser for the bus pins and the sector selects.
// Assumes address, data and selects are stable around the strobe edges.
`timescale 1ns/1ps
`default_nettype none
module fcd_pin_sync
  import fcd_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic             wr_n_i,
  input  wire logic             rd_n_i,
  input  wire logic             byte_i,
  input  wire logic [AW-1:0]    addr_i,
  input  wire logic [DW-1:0]    data_i,
  input  wire logic [NSECT-1:0] sel_i,
  fcd_bus_if.src                bus
);
  localparam int W = 3 + AW + DW + NSECT;

  typedef struct packed {
    logic [W-1:0] m;
    logic [W-1:0] o;
  } fcd_sync_t;

  fcd_sync_t s_q;
  fcd_sync_t s_d;

  // Selects also pass both stages so they stay aligned with the strobes.
  always_comb
  begin
    s_d   = s_q;
    s_d.m = {wr_n_i, rd_n_i, byte_i, addr_i, data_i, sel_i};
    s_d.o = s_q.m;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      s_q <= {STROBE_IDLE, {(W - 2){1'b0}}, STROBE_IDLE, {(W - 2){1'b0}}};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign {bus.wr_n, bus.rd_n, bus.byte_wr, bus.addr, bus.data, bus.sel} = s_q.o;
endmodule : fcd_pin_sync
`default_nettype wire

// ==== src/fcd_timer.sv ====
// Reloadable down-counter that pulses once when its interval runs out.
// Assumes N is at least one; a load in the firing cycle restarts it.
`timescale 1ns/1ps
`default_nettype none
module fcd_timer
  import fcd_pkg::*;
#(
  parameter logic [TW-1:0] N = TW'(IBT_CYC)
)
(
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic load_i,
  input  wire logic clear_i,
  output logic      fire_o
);
  typedef struct packed {
    logic [TW-1:0] cnt;
  } fcd_tmr_t;

  fcd_tmr_t s_q;
  fcd_tmr_t s_d;

  always_comb
  begin
    s_d = s_q;
    if (load_i)
    begin
      s_d.cnt = N;
    end
    else if (clear_i)
    begin
      s_d.cnt = '0;
    end
    else if (s_q.cnt != '0)
    begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign fire_o = (s_q.cnt == TW'(1)) & ~load_i & ~clear_i;
endmodule : fcd_timer
`default_nettype wire

// ==== src/fcd_top.sv ====
// Flash command decoder: turns bus write sequences into flash operations.
// Assumes an embedded algorithm engine reports busy and done beside it.
// What this block does
// RULE1 - Decode bytes in sequence, execute when complete
// RULE2 - Bad sequence or time-out returns to read, or to bypass from bypass mode
// RULE3 - Sequences open with AA@AAA, 55@554
// RULE4 - Match only the low twelve address bits
// RULE5 - Master holds the sector select every cycle
// RULE6 - Route to the array whose select is active
// RULE7 - Info read at 02 gives main identifier
// RULE8 - Info read at 04 gives protection bit
// RULE9 - Program: unlock, A0@AAA, then data word
// RULE10 - Address at strobe fall, data at rise
// RULE11 - Erase: unlock, 80, unlock, 30 or 10
// RULE12 - More sectors queue within the window
// RULE13 - B0 suspends only a running sector erase
// RULE14 - 30 resumes only while erase is suspended
// RULE15 - Suspended erase allows reads and other programs
// RULE16 - F0 returns to read-array mode, except in bypass mode
// RULE17 - Bypass mode: A0 then data programs
// RULE18 - Bypass left by 90 then 00
// RULE19 - Plain reads return the array in read mode
// RULE20 - Command bytes even except in bypass mode, program word even
// RULE21 - Reset starts in read-array mode
// RULE22 - Master keeps selects and strobe idle at power-up
// RULE23 - Master never commands the array it runs from
// RULE24 - Protected targets are ignored, status reverts later; a protected program shows no busy, only an all-protected erase holds BUSY_O
// RULE25 - Inter-byte time-out is a restartable counter
// RULE26 - While busy only erase suspend is taken
`timescale 1ns/1ps
`default_nettype none
module fcd_top
  import fcd_pkg::*;
#(
  parameter int unsigned   IBT_CYCLES       = IBT_CYC,
  parameter int unsigned   ERASE_WIN_CYCLES = ERASE_WIN_CYC,
  parameter int unsigned   PROT_REV_CYCLES  = PROT_REV_CYC,
  // Identifier value is arbitrary.
  parameter logic [7:0]    MAIN_ID_CODE     = 8'h5A
)
(
  input  wire logic                     CLOCK_I,
  input  wire logic                     RSTN_I,
  input  wire logic                     WR_N_I,
  input  wire logic                     RD_N_I,
  input  wire logic                     BYTE_I,
  input  wire logic [fcd_pkg::AW-1:0]   ADDR_I,
  input  wire logic [fcd_pkg::DW-1:0]   DATA_I,
  input  wire logic [fcd_pkg::NMAIN-1:0] MAIN_SECTOR_SELECTS_I,
  input  wire logic [fcd_pkg::NSEC-1:0] SECONDARY_SECTOR_SELECTS_I,
  input  wire logic [fcd_pkg::NSECT-1:0] PROTECT_I,
  input  wire logic                     ALG_BUSY_I,
  input  wire logic                     ALG_DONE_I,
  output logic                          PROG_GO_O,
  output logic [fcd_pkg::AW-1:0]        PROGRAM_TARGET_ADDRESS_O,
  output logic [fcd_pkg::DW-1:0]        PROGRAM_WORD_O,
  output logic                          PROG_SECONDARY_O,
  output logic                          ERASE_GO_O,
  output logic                          ERASE_BULK_O,
  output logic [fcd_pkg::NSECT-1:0]     ERASE_MASK_O,
  output logic                          SUSPEND_GO_O,
  output logic                          RESUME_GO_O,
  output logic                          SUSPENDED_O,
  output logic                          READ_ARRAY_O,
  output logic                          ARRAY_RD_O,
  output logic                          INFO_OE_O,
  output logic [7:0]                    INFO_DATA_O,
  output logic                          BUSY_O
);
  typedef struct packed {
    fcd_state_t       st;
    logic             wrp;
    logic [AW-1:0]    a;
    logic [NSECT-1:0] sm;
    logic             prun;
    logic             erasing;
    logic             bulk;
    logic             susp;
    logic             pwait;
    logic [NSECT-1:0] emask;
    logic             pgo;
    logic             ego;
    logic             sgo;
    logic             rgo;
    logic             psec;
    logic [AW-1:0]    pa;
    logic [DW-1:0]    pw;
    logic             iboe;
    logic             ardo;
    logic [7:0]       info;
  } fcd_regs_t;

  fcd_bus_if b ();
  fcd_regs_t s_q;
  fcd_regs_t s_d;
  logic [7:0]       d;
  logic             wr_rise;
  logic             cyc_ok;
  logic             word_ok;
  logic             rej;
  logic             mid;
  logic             byp_side;
  logic             go_erase;
  logic [NSECT-1:0] go_mask;
  logic             ld_ibt;
  logic             ld_win;
  logic             ld_prv;
  logic             ibt_fire;
  logic             win_fire;
  logic             prv_fire;
  logic             rd_main;

  function automatic logic at(input logic [AW-1:0] a, input logic [11:0] k);
    at = (a[11:0] == k); // RULE4
  endfunction : at

  fcd_pin_sync u_sync (
    .clk_i  (CLOCK_I),
    .rstn_i (RSTN_I),
    .wr_n_i (WR_N_I),
    .rd_n_i (RD_N_I),
    .byte_i (BYTE_I),
    .addr_i (ADDR_I),
    .data_i (DATA_I),
    .sel_i  ({SECONDARY_SECTOR_SELECTS_I, MAIN_SECTOR_SELECTS_I}),
    .bus    (b)
  );

  fcd_timer #(.N(TW'(IBT_CYCLES))) u_ibt (
    .clk_i (CLOCK_I), .rstn_i (RSTN_I), .load_i (ld_ibt),
    .clear_i (s_q.st == ST_READ), .fire_o (ibt_fire)
  ); // RULE25
  fcd_timer #(.N(TW'(ERASE_WIN_CYCLES))) u_win (
    .clk_i (CLOCK_I), .rstn_i (RSTN_I), .load_i (ld_win),
    .clear_i (1'b0), .fire_o (win_fire)
  );
  fcd_timer #(.N(TW'(PROT_REV_CYCLES))) u_prv (
    .clk_i (CLOCK_I), .rstn_i (RSTN_I), .load_i (ld_prv),
    .clear_i (1'b0), .fire_o (prv_fire)
  );

  assign d        = b.data[7:0];
  assign wr_rise  = ~s_q.wrp & b.wr_n;
  assign cyc_ok   = b.byte_wr & ~s_q.a[0]; // RULE20
  assign word_ok  = ~b.byte_wr & ~s_q.a[0]; // RULE20
  // A running or faked operation must not be disturbed by a new sequence.
  assign rej      = ALG_BUSY_I | s_q.pwait | s_q.prun; // RULE26
  assign byp_side = (s_q.st == ST_BPROG) | (s_q.st == ST_BRST);
  assign mid      = |(s_q.st & (ST_C1 | ST_C2 | ST_PROG | ST_E1 | ST_E2 | ST_E3 | ST_BPROG | ST_BRST));
  assign rd_main  = |b.sel[NMAIN-1:0];

  always_comb
  begin
    s_d      = s_q;
    s_d.pgo  = 1'b0;
    s_d.ego  = 1'b0;
    s_d.sgo  = 1'b0;
    s_d.rgo  = 1'b0;
    s_d.wrp  = b.wr_n;
    go_erase = 1'b0;
    go_mask  = '0;
    ld_ibt   = 1'b0;
    ld_win   = 1'b0;
    ld_prv   = 1'b0;
    if (s_q.wrp & ~b.wr_n)
    begin
      s_d.a  = b.addr; // RULE10
      s_d.sm = b.sel;
    end
    if (ALG_DONE_I)
    begin
      if (s_q.prun)
      begin
        s_d.prun = 1'b0;
      end
      else if (!s_q.susp)
      begin
        s_d.erasing = 1'b0;
        s_d.bulk    = 1'b0;
        s_d.emask   = '0;
      end
    end
    if (prv_fire)
    begin
      s_d.pwait = 1'b0; // RULE24
    end
    if (ibt_fire && mid)
    begin
      s_d.st = byp_side ? ST_BYP : ST_READ; // RULE2
    end
    if (win_fire && s_q.st == ST_EQ)
    begin
      go_erase = 1'b1; // RULE12
      go_mask  = s_q.emask;
      s_d.st   = ST_READ;
    end
    // Writes without any sector select are not flash cycles at all.
    if (wr_rise && |s_q.sm) // RULE5
    begin
      ld_ibt = 1'b1; // RULE25
      if (cyc_ok && d == CMD_SUSP)
      begin
        if (s_q.erasing && !s_q.bulk && !s_q.susp)
        begin
          s_d.sgo  = 1'b1; // RULE13
          s_d.susp = 1'b1;
        end
      end
      else if (!rej)
      begin
        if (cyc_ok && d == CMD_RESET && !byp_side && s_q.st != ST_BYP)
        begin
          s_d.st = ST_READ; // RULE16
        end
        else
        begin
          case (s_q.st) // RULE1
            ST_READ, ST_INFO:
            begin
              if (cyc_ok && d == CMD_UNLK1 && at(s_q.a, ADDR_UNLK1))
              begin
                s_d.st = ST_C1; // RULE3
              end
              else if (cyc_ok && s_q.susp && d == CMD_RESUME)
              begin
                s_d.rgo  = 1'b1; // RULE14
                s_d.susp = 1'b0;
              end
            end
            ST_C1:
            begin
              s_d.st = (cyc_ok && d == CMD_UNLK2 && at(s_q.a, ADDR_UNLK2)) ? ST_C2 : ST_READ;
            end
            ST_C2:
            begin
              s_d.st = ST_READ; // RULE2
              if (cyc_ok && at(s_q.a, ADDR_UNLK1))
              begin
                if (d == CMD_INFO)
                begin
                  s_d.st = ST_INFO; // RULE15
                end
                else if (d == CMD_PROG)
                begin
                  s_d.st = ST_PROG; // RULE9
                end
                else if (d == CMD_ERASE && !s_q.susp)
                begin
                  s_d.st = ST_E1; // RULE11
                end
                else if (d == CMD_BYPASS && !s_q.susp)
                begin
                  s_d.st = ST_BYP; // RULE17
                end
              end
            end
            ST_PROG, ST_BPROG:
            begin
              s_d.st = (s_q.st == ST_PROG) ? ST_READ : ST_BYP;
              // Protected targets and sectors under suspended erase are ignored.
              if (word_ok && !(|(s_q.sm & PROTECT_I)) && !(s_q.susp && |(s_q.sm & s_q.emask)))
              begin
                s_d.pgo  = 1'b1; // RULE24
                s_d.prun = 1'b1; // RULE15
                s_d.pa   = s_q.a;
                s_d.pw   = b.data; // RULE10
                s_d.psec = ~(|s_q.sm[NMAIN-1:0]); // RULE6
              end
            end
            ST_E1:
            begin
              s_d.st = (cyc_ok && d == CMD_UNLK1 && at(s_q.a, ADDR_UNLK1)) ? ST_E2 : ST_READ;
            end
            ST_E2:
            begin
              s_d.st = (cyc_ok && d == CMD_UNLK2 && at(s_q.a, ADDR_UNLK2)) ? ST_E3 : ST_READ;
            end
            ST_E3:
            begin
              s_d.st = ST_READ;
              if (cyc_ok && d == CMD_SECT)
              begin
                s_d.st    = ST_EQ; // RULE11
                s_d.emask = s_q.sm;
                ld_win    = 1'b1;
              end
              else if (cyc_ok && d == CMD_BULK && at(s_q.a, ADDR_UNLK1))
              begin
                go_erase = 1'b1;
                s_d.bulk = 1'b1;
                go_mask  = (|s_q.sm[NMAIN-1:0]) ? {{NSEC{1'b0}}, {NMAIN{1'b1}}}
                                                : {{NSEC{1'b1}}, {NMAIN{1'b0}}}; // RULE6
              end
            end
            ST_EQ:
            begin
              if (cyc_ok && d == CMD_SECT)
              begin
                s_d.emask = s_q.emask | s_q.sm; // RULE12
                ld_win    = 1'b1;
              end
              else
              begin
                s_d.st    = ST_READ;
                s_d.emask = '0;
              end
            end
            ST_BYP:
            begin
              if (d == CMD_PROG)
              begin
                s_d.st = ST_BPROG; // RULE17
              end
              else if (d == CMD_INFO)
              begin
                s_d.st = ST_BRST; // RULE18
              end
            end
            ST_BRST:
            begin
              s_d.st = (d == CMD_BYP_EXIT) ? ST_READ : ST_BYP; // RULE18
            end
            default:
            begin
              s_d.st = ST_READ;
            end
          endcase
        end
      end
    end
    if (go_erase)
    begin
      if (|(go_mask & ~PROTECT_I))
      begin
        s_d.ego     = 1'b1;
        s_d.erasing = 1'b1;
        s_d.emask   = go_mask & ~PROTECT_I;
      end
      else
      begin
        s_d.pwait = 1'b1; // RULE24
        s_d.bulk  = 1'b0;
        s_d.emask = '0;
        ld_prv    = 1'b1;
      end
    end
    s_d.ardo = ~b.rd_n & |b.sel & (s_q.st != ST_INFO); // RULE19
    s_d.iboe = 1'b0;
    s_d.info = PROT_NO;
    if (~b.rd_n && s_q.st == ST_INFO)
    begin
      if (b.addr[7:0] == INFO_ID_OFS && rd_main)
      begin
        s_d.iboe = 1'b1; // RULE7
        s_d.info = MAIN_ID_CODE;
      end
      else if (b.addr[7:0] == INFO_PROT_OFS && |b.sel)
      begin
        s_d.iboe = 1'b1; // RULE8
        s_d.info = |(b.sel & PROTECT_I) ? PROT_YES : PROT_NO;
      end
    end
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (!RSTN_I)
    begin
      s_q     <= '0;
      s_q.st  <= ST_READ; // RULE21
      s_q.wrp <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign PROG_GO_O                = s_q.pgo;
  assign PROGRAM_TARGET_ADDRESS_O = s_q.pa;
  assign PROGRAM_WORD_O           = s_q.pw;
  assign PROG_SECONDARY_O         = s_q.psec;
  assign ERASE_GO_O               = s_q.ego;
  assign ERASE_BULK_O             = s_q.bulk;
  assign ERASE_MASK_O             = s_q.emask;
  assign SUSPEND_GO_O             = s_q.sgo;
  assign RESUME_GO_O              = s_q.rgo;
  assign SUSPENDED_O              = s_q.susp;
  assign READ_ARRAY_O             = (s_q.st == ST_READ);
  assign ARRAY_RD_O               = s_q.ardo;
  assign INFO_OE_O                = s_q.iboe;
  assign INFO_DATA_O              = s_q.info;
  assign BUSY_O                   = ALG_BUSY_I | s_q.pwait;

  property p_reset_read;
    @(posedge CLOCK_I) disable iff (!RSTN_I) $rose(RSTN_I) |-> READ_ARRAY_O;
  endproperty
  a_reset_read: assert property (p_reset_read) else $error("not in read mode after reset"); // RULE21

  property p_timeout;
    @(posedge CLOCK_I) disable iff (!RSTN_I)
      (ibt_fire && mid && !wr_rise) |=> (s_q.st == ST_READ || s_q.st == ST_BYP);
  endproperty
  a_timeout: assert property (p_timeout) else $error("time-out did not abandon sequence"); // RULE2

  property p_suspend;
    @(posedge CLOCK_I) disable iff (!RSTN_I)
      SUSPEND_GO_O |-> $past(s_q.erasing) && !$past(s_q.bulk) && !$past(s_q.susp) && SUSPENDED_O;
  endproperty
  a_suspend: assert property (p_suspend) else $error("suspend outside sector erase"); // RULE13

  property p_resume;
    @(posedge CLOCK_I) disable iff (!RSTN_I) RESUME_GO_O |-> $past(s_q.susp) && !SUSPENDED_O;
  endproperty
  a_resume: assert property (p_resume) else $error("resume outside suspend"); // RULE14

  property p_busy_reject;
    @(posedge CLOCK_I) disable iff (!RSTN_I) PROG_GO_O |-> !$past(ALG_BUSY_I) && !$past(s_q.prun);
  endproperty
  a_busy_reject: assert property (p_busy_reject) else $error("program taken while busy"); // RULE26

  property p_prog_protect;
    @(posedge CLOCK_I) disable iff (!RSTN_I) PROG_GO_O |-> !$past(|(s_q.sm & PROTECT_I));
  endproperty
  a_prog_protect: assert property (p_prog_protect) else $error("protected sector programmed"); // RULE24

  property p_prog_seq;
    @(posedge CLOCK_I) disable iff (!RSTN_I)
      PROG_GO_O |-> $past(s_q.st == ST_PROG || s_q.st == ST_BPROG) && $past(wr_rise);
  endproperty
  a_prog_seq: assert property (p_prog_seq) else $error("program without full sequence"); // RULE17

  property p_main_id;
    @(posedge CLOCK_I) disable iff (!RSTN_I)
      (s_q.st == ST_INFO && !b.rd_n && b.addr[7:0] == INFO_ID_OFS && rd_main)
      |=> INFO_OE_O && INFO_DATA_O == MAIN_ID_CODE;
  endproperty
  a_main_id: assert property (p_main_id) else $error("identifier read wrong"); // RULE7

  property p_reset_cmd;
    @(posedge CLOCK_I) disable iff (!RSTN_I)
      (wr_rise && |s_q.sm && cyc_ok && d == CMD_RESET && !rej && !byp_side && s_q.st != ST_BYP)
      |=> READ_ARRAY_O;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("reset command ignored"); // RULE16
endmodule : fcd_top
`default_nettype wire

// ==== dv/fcd_mcu_model.sv ====
// Bus master model: strobed byte or word writes and reads towards the decoder.
// Assumes the decoder synchronises its pins, so every phase lasts a few clocks.
`timescale 1ns/1ps
`default_nettype none
module fcd_mcu_model
(
  input  wire logic                      clk_i,
  input  wire logic [9:0]                rdata_i,
  output logic                           wr_n_o,
  output logic                           rd_n_o,
  output logic                           byte_o,
  output logic [fcd_pkg::AW-1:0]         addr_o,
  output logic [fcd_pkg::DW-1:0]         data_o,
  output logic [fcd_pkg::NSECT-1:0]      sel_o
);
  import fcd_pkg::*;
  // Strobes and selects start idle so the first strobe edge writes nothing.
  initial
  begin
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
    byte_o = 1'b1;
    addr_o = 16'h0000;
    data_o = 16'h0000;
    sel_o  = '0;
  end

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d, input logic b,
                    input logic [NSECT-1:0] s);
    @(posedge clk_i);
    #1;
    addr_o = a;
    data_o = d;
    byte_o = b;
    sel_o  = s;
    wr_n_o = 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    wr_n_o = 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    // A released bus shows the inverse address and data and no select, never the stale value.
    addr_o = ~a;
    data_o = ~d;
    sel_o  = '0;
    repeat (2) @(posedge clk_i);
  endtask : wr

  task automatic rd(input logic [AW-1:0] a, input logic [NSECT-1:0] s, output logic [9:0] r);
    @(posedge clk_i);
    #1;
    addr_o = a;
    sel_o  = s;
    rd_n_o = 1'b0;
    repeat (5) @(posedge clk_i);
    r = rdata_i;
    #1;
    rd_n_o = 1'b1;
    sel_o  = '0;
    addr_o = ~a;
  endtask : rd
endmodule : fcd_mcu_model
`default_nettype wire

// ==== dv/tb_fcd_top.sv ====
// Self-checking bench for the flash command decoder, one task per scenario.
// Assumes shortened time-out and window parameters; the bench acts as engine.
`timescale 1ns/1ps
`default_nettype none
module tb_fcd_top;
  import fcd_pkg::*;
  localparam int unsigned IBT = 64;
  localparam int unsigned EWIN = 50;
  localparam int unsigned PREV = 50;
  // Identifier value is arbitrary.
  localparam logic [7:0]  ID = 8'hC3;
  logic        clk = 1'b0, rstn = 1'b0, busy_in = 1'b0, done_in = 1'b0;
  logic        wr_n, rd_n, byte_w, pgo, psec, ego, ebulk, sgo, rgo, susp, rarr, ard, ioe, bsy;
  logic [15:0] addr, data, pa, pw, cnt;
  logic [11:0] sel, emask, prot_in = 12'h000;
  logic [7:0]  idat;
  logic [9:0]  r;
  logic [3:0]  np, ne, ns, nr;
  int          miscompares = 0, n_tests = 0, cyc = 0;
  assign cnt = {np, ne, ns, nr};
  always #2.5 clk = ~clk;

  fcd_mcu_model mcu_i (.clk_i(clk), .rdata_i({ard, ioe, idat}), .wr_n_o(wr_n), .rd_n_o(rd_n),
    .byte_o(byte_w), .addr_o(addr), .data_o(data), .sel_o(sel));
  fcd_top #(.IBT_CYCLES(IBT), .ERASE_WIN_CYCLES(EWIN), .PROT_REV_CYCLES(PREV), .MAIN_ID_CODE(ID))
  fcd_top_i (.CLOCK_I(clk), .RSTN_I(rstn), .WR_N_I(wr_n), .RD_N_I(rd_n), .BYTE_I(byte_w),
    .ADDR_I(addr), .DATA_I(data), .MAIN_SECTOR_SELECTS_I(sel[7:0]),
    .SECONDARY_SECTOR_SELECTS_I(sel[11:8]), .PROTECT_I(prot_in), .ALG_BUSY_I(busy_in),
    .ALG_DONE_I(done_in), .PROG_GO_O(pgo), .PROGRAM_TARGET_ADDRESS_O(pa), .PROGRAM_WORD_O(pw),
    .PROG_SECONDARY_O(psec), .ERASE_GO_O(ego), .ERASE_BULK_O(ebulk), .ERASE_MASK_O(emask),
    .SUSPEND_GO_O(sgo), .RESUME_GO_O(rgo), .SUSPENDED_O(susp), .READ_ARRAY_O(rarr),
    .ARRAY_RD_O(ard), .INFO_OE_O(ioe), .INFO_DATA_O(idat), .BUSY_O(bsy));

  always @(posedge clk)
  begin
    np <= !rstn ? 4'h0 : np + 4'(pgo === 1'b1);
    ne <= !rstn ? 4'h0 : ne + 4'(ego === 1'b1);
    ns <= !rstn ? 4'h0 : ns + 4'(sgo === 1'b1);
    nr <= !rstn ? 4'h0 : nr + 4'(rgo === 1'b1);
    cyc++;
    if (cyc == 6000)
    begin
      miscompares++;
      final_report();
    end
  end

  task automatic final_report();
    $display("compares=%0d mismatches=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic w(input logic [15:0] a, input logic [7:0] d, input logic [11:0] s);
    mcu_i.wr(a, {8'h00, d}, 1'b1, s);
  endtask : w

  // Upper address bits are set on purpose; only the low twelve must match.
  task automatic cmd(input logic [7:0] c, input logic [11:0] s);
    w(16'hFAAA, CMD_UNLK1, s);
    w(16'h3554, CMD_UNLK2, s);
    w(16'h5AAA, c, s);
  endtask : cmd

  task automatic done();
    @(posedge clk);
    #1;
    done_in = 1'b1;
    busy_in = 1'b0;
    @(posedge clk);
    #1;
    done_in = 1'b0;
  endtask : done

  task automatic t_reset();
    chk({15'h0, rarr}, 16'h0001);
    w(16'h0000, CMD_SUSP, 12'h001);
    chk(cnt, 16'h0000);
  endtask : t_reset

  task automatic t_prog();
    cmd(CMD_PROG, 12'h001);
    mcu_i.wr(16'h7F12, 16'hBEEF, 1'b0, 12'h002);
    chk(cnt, 16'h1000);
    chk(pa, 16'h7F12);
    chk(pw, 16'hBEEF);
    done();
    cmd(CMD_PROG, 12'h100);
    mcu_i.wr(16'h0104, 16'h1234, 1'b0, 12'h100);
    chk({15'h0, psec}, 16'h0001);
    chk(cnt, 16'h2000);
    done();
  endtask : t_prog

  task automatic t_bad();
    w(16'h0AAA, CMD_UNLK1, 12'h001);
    w(16'h0554, 8'h56, 12'h001);
    w(16'h0AAA, CMD_PROG, 12'h001);
    mcu_i.wr(16'h0010, 16'h1111, 1'b0, 12'h001);
    chk({15'h0, rarr}, 16'h0001);
    w(16'h0AAA, CMD_UNLK1, 12'h001);
    repeat (IBT + 10) @(posedge clk);
    w(16'h0554, CMD_UNLK2, 12'h001);
    w(16'h0AAA, CMD_PROG, 12'h001);
    mcu_i.wr(16'h0010, 16'h2222, 1'b0, 12'h001);
    #1 prot_in = 12'h008;
    cmd(CMD_PROG, 12'h008);
    mcu_i.wr(16'h3000, 16'h3333, 1'b0, 12'h008);
    cmd(CMD_ERASE, 12'h008);
    cmd(CMD_SECT, 12'h008);
    repeat (EWIN + 10) @(posedge clk);
    chk({15'h0, bsy}, 16'h0001);
    repeat (PREV) @(posedge clk);
    chk({15'h0, bsy}, 16'h0000);
    chk(cnt, 16'h2000);
  endtask : t_bad

  task automatic t_info();
    cmd(CMD_INFO, 12'h001);
    mcu_i.rd(16'h5502, 12'h001, r);
    chk({6'h0, r}, {8'h01, ID});
    mcu_i.rd(16'h3004, 12'h008, r);
    chk({6'h0, r}, {8'h01, PROT_YES});
    mcu_i.rd(16'h0004, 12'h001, r);
    chk({6'h0, r}, {8'h01, PROT_NO});
    chk({15'h0, rarr}, 16'h0000);
    w(16'h1236, CMD_RESET, 12'h001);
    chk({15'h0, rarr}, 16'h0001);
    mcu_i.rd(16'h1234, 12'h001, r);
    chk({14'h0, r[9:8]}, 16'h0002);
  endtask : t_info

  task automatic t_erase();
    cmd(CMD_ERASE, 12'h001);
    cmd(CMD_BULK, 12'h001);
    chk(cnt, 16'h2100);
    chk({15'h0, ebulk}, 16'h0001);
    #1 busy_in = 1'b1;
    cmd(CMD_PROG, 12'h001);
    mcu_i.wr(16'h0010, 16'h4444, 1'b0, 12'h001);
    chk(cnt, 16'h2100);
    done();
    cmd(CMD_ERASE, 12'h004);
    w(16'h0AAA, CMD_UNLK1, 12'h004);
    w(16'h0554, CMD_UNLK2, 12'h004);
    w(16'h2000, CMD_SECT, 12'h004);
    w(16'h5000, CMD_SECT, 12'h020);
    repeat (EWIN + 10) @(posedge clk);
    chk(cnt, 16'h2200);
    chk({4'h0, emask}, 16'h0024);
    #1 busy_in = 1'b1;
    w(16'h0000, CMD_SUSP, 12'h004);
    chk(cnt, 16'h2210);
    #1 busy_in = 1'b0;
    chk({15'h0, susp}, 16'h0001);
    cmd(CMD_PROG, 12'h001);
    mcu_i.wr(16'h0010, 16'h5555, 1'b0, 12'h001);
    chk(cnt, 16'h3210);
    done();
    w(16'h0000, CMD_RESUME, 12'h004);
    chk(cnt, 16'h3211);
    #1 busy_in = 1'b1;
    done();
  endtask : t_erase

  task automatic t_bypass();
    cmd(CMD_BYPASS, 12'h001);
    w(16'h0002, CMD_PROG, 12'h001);
    mcu_i.wr(16'h0020, 16'hA5A5, 1'b0, 12'h001);
    chk(cnt, 16'h4211);
    chk({15'h0, rarr}, 16'h0000);
    done();
    w(16'h0000, CMD_INFO, 12'h001);
    w(16'h0000, CMD_BYP_EXIT, 12'h001);
    chk({15'h0, rarr}, 16'h0001);
  endtask : t_bypass

  initial
  begin
    repeat (8) @(posedge clk);
    #1;
    rstn = 1'b1;
    t_reset();
    t_prog();
    t_bad();
    t_info();
    t_erase();
    t_bypass();
    final_report();
  end
endmodule : tb_fcd_top
`default_nettype wire
